// *** rtl/bresp_fifo.sv ***
// Write response channel FIFO: master-side B port in, slave-side B port out,
// programmable flags, ECC with injection and an APB control/status slave.
// Assumes both AXI partners and the APB master run on I_MCLK.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module bresp_fifo
    import bresp_fifo_pkg::*;
(
    // Clock and reset
    input  wire logic                                I_MCLK,
    input  wire logic                                I_SRST,
    // Master-side write response port
    input  wire logic [bresp_fifo_pkg::ID_W-1:0]     I_M_BID,
    input  wire logic [bresp_fifo_pkg::RESP_W-1:0]   I_M_BRESP,
    input  wire logic [bresp_fifo_pkg::USER_W-1:0]   I_M_BUSER,
    input  wire logic                                I_M_BVALID,
    output logic                                     O_M_BREADY,
    // Slave-side write response port
    output logic [bresp_fifo_pkg::ID_W-1:0]          O_S_BID,
    output logic [bresp_fifo_pkg::RESP_W-1:0]        O_S_BRESP,
    output logic [bresp_fifo_pkg::USER_W-1:0]        O_S_BUSER,
    output logic                                     O_S_BVALID,
    input  wire logic                                I_S_BREADY,
    // Sideband
    input  wire logic [bresp_fifo_pkg::THRESH_W-1:0] I_PROG_FULL_THRESH,
    input  wire logic [bresp_fifo_pkg::THRESH_W-1:0] I_PROG_EMPTY_THRESH,
    input  wire logic                                I_INJECT_SBIT,
    input  wire logic                                I_INJECT_DBIT,
    output logic                                     O_SBIT_ERR,
    output logic                                     O_DBIT_ERR,
    output logic                                     O_OVERFLOW,
    output logic                                     O_PROG_FULL,
    output logic                                     O_PROG_EMPTY,
    output logic [bresp_fifo_pkg::CNT_W-1:0]         O_DATA_COUNT,
    // APB slave
    input  wire logic                                I_PSEL,
    input  wire logic                                I_PENABLE,
    input  wire logic                                I_PWRITE,
    input  wire logic [bresp_fifo_pkg::ADDR_W-1:0]   I_PADDR,
    input  wire logic [bresp_fifo_pkg::DATA_W-1:0]   I_PWDATA,
    output logic [bresp_fifo_pkg::DATA_W-1:0]        O_PRDATA,
    output logic                                     O_PREADY,
    output logic                                     O_PSLVERR
);
    import bresp_fifo_pkg::*;

    state_t  s;
    state_t  next_s;
    store_if st ();

    logic    push;
    logic    pop_mem;
    logic    mem_full;
    cnt_t    total;

    // ****************************************************************
    // Storage
    // ****************************************************************
    ecc_store u_store
    (
        .i_clk (I_MCLK),
        .st    (st)
    );

    assign st.wr_en      = push;
    assign st.wr_addr    = s.wr_ptr;
    assign st.wr_data    = {I_M_BID, I_M_BRESP, I_M_BUSER};
    assign st.inj_single = I_INJECT_SBIT;
    assign st.inj_double = I_INJECT_DBIT;
    assign st.ecc_en     = s.ecc_en;
    assign st.rd_addr    = s.rd_ptr;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_s   = s;
        mem_full = (s.mem_cnt == CNT_W'(DEPTH));
        // Downstream BVALID is only meaningful so no extra checks
        push     = I_M_BVALID && s.bready;
        pop_mem  = (!s.out_valid || I_S_BREADY) && (s.mem_cnt != '0);
        total    = '0;

        // Output stage: front word held until the upstream handshake
        if (s.out_valid && I_S_BREADY)
            next_s.out_valid = 1'b0;
        next_s.sbit = 1'b0;
        next_s.dbit = 1'b0;
        if (pop_mem)
        begin
            next_s.out_valid = 1'b1;
            next_s.out_word  = st.rd_data;
            next_s.rd_ptr    = s.rd_ptr + 1'b1;
            next_s.sbit      = st.rd_single;
            next_s.dbit      = st.rd_double;
        end
        if (push)
            next_s.wr_ptr = s.wr_ptr + 1'b1;
        next_s.mem_cnt = s.mem_cnt + CNT_W'(push) - CNT_W'(pop_mem);

        // Registered ready keeps a write out of a full store
        next_s.bready   = (next_s.mem_cnt != CNT_W'(DEPTH));
        next_s.overflow = I_M_BVALID && !s.bready && mem_full;

        total          = next_s.mem_cnt + CNT_W'(next_s.out_valid);
        next_s.count   = total;
        next_s.prog_full  = (total >= CNT_W'(s.full_th));
        next_s.prog_empty = (total <= CNT_W'(s.empty_th));

        // APB: answer is prepared in setup, pready rises in access
        next_s.pready  = I_PSEL && !I_PENABLE;
        next_s.pslverr = 1'b0;
        if (I_PSEL && !I_PENABLE)
        begin
            next_s.prdata = '0;
            if (I_PADDR == CTRL_OFFSET)
                next_s.prdata[CTRL_ECC_EN_POS] = s.ecc_en;
            else if (I_PADDR == STATUS_OFFSET)
            begin
                next_s.prdata[STAT_COUNT_LSB +: CNT_W]    = s.count;
                next_s.prdata[STAT_FULL_POS]              = mem_full;
                next_s.prdata[STAT_EMPTY_POS]             = (s.count == '0);
                next_s.prdata[STAT_PFULL_POS]             = s.prog_full;
                next_s.prdata[STAT_PEMPTY_POS]            = s.prog_empty;
                next_s.prdata[STAT_FTH_LSB +: THRESH_W]   = s.full_th;
                next_s.prdata[STAT_ETH_LSB +: THRESH_W]   = s.empty_th;
            end
            else
                next_s.pslverr = 1'b1;
        end
        else if (I_PSEL && I_PENABLE)
            next_s.pslverr = s.pslverr;
        if (I_PSEL && I_PENABLE && s.pready && I_PWRITE && (I_PADDR == CTRL_OFFSET))
            next_s.ecc_en = I_PWDATA[CTRL_ECC_EN_POS];

        if (I_SRST)
        begin
            next_s            = '0;
            next_s.bready     = 1'b1;
            next_s.prog_empty = 1'b1;
            next_s.ecc_en     = CTRL_ECC_EN_RESET;
            // Thresholds are sampled only while reset is held
            next_s.full_th    = I_PROG_FULL_THRESH;
            next_s.empty_th   = I_PROG_EMPTY_THRESH;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge I_MCLK)
    begin
        s <= next_s;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign O_M_BREADY   = s.bready;
    assign O_S_BID      = s.out_word[ID_LSB +: ID_W];
    assign O_S_BRESP    = s.out_word[RESP_LSB +: RESP_W];
    assign O_S_BUSER    = s.out_word[USER_LSB +: USER_W];
    assign O_S_BVALID   = s.out_valid;
    assign O_SBIT_ERR   = s.sbit;
    assign O_DBIT_ERR   = s.dbit;
    assign O_OVERFLOW   = s.overflow;
    assign O_PROG_FULL  = s.prog_full;
    assign O_PROG_EMPTY = s.prog_empty;
    assign O_DATA_COUNT = s.count;
    assign O_PRDATA     = s.prdata;
    assign O_PREADY     = s.pready;
    assign O_PSLVERR    = s.pslverr;
endmodule

// *** rtl/bresp_fifo_pkg.sv ***
// Shared constants, types and field layouts of the write response FIFO.
// Assumes a single 40 MHz clock domain and synchronous active-high reset.
package bresp_fifo_pkg;

    // ****************************************************************
    // Word layout
    // ****************************************************************
    localparam int ID_W    = 4;
    localparam int RESP_W  = 2;
    localparam int USER_W  = 1;
    localparam int WORD_W  = ID_W + RESP_W + USER_W;
    localparam int USER_LSB = 0;
    localparam int RESP_LSB = USER_W;
    localparam int ID_LSB   = USER_W + RESP_W;

    // ****************************************************************
    // Storage geometry
    // ****************************************************************
    localparam int DEPTH    = 16;
    localparam int PTR_W    = $clog2(DEPTH);
    localparam int THRESH_W = PTR_W;
    localparam int CNT_W    = PTR_W + 1;
    localparam int PAR_W    = 4;
    localparam int CODE_W   = WORD_W + PAR_W + 1;
    // Data bits that injection flips
    localparam int INJ_BIT_A = 3;
    localparam int INJ_BIT_B = 5;

    // ****************************************************************
    // Register bus map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam int CTRL_ECC_EN_POS  = 0;
    localparam logic CTRL_ECC_EN_RESET = 1'b1;
    localparam int STAT_COUNT_LSB   = 0;
    localparam int STAT_FULL_POS    = 5;
    localparam int STAT_EMPTY_POS   = 6;
    localparam int STAT_PFULL_POS   = 7;
    localparam int STAT_PEMPTY_POS  = 8;
    localparam int STAT_FTH_LSB     = 16;
    localparam int STAT_ETH_LSB     = 20;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [CODE_W-1:0] code_t;
    typedef logic [PTR_W-1:0]  ptr_t;
    typedef logic [CNT_W-1:0]  cnt_t;
    typedef logic [THRESH_W-1:0] thresh_t;

    typedef struct packed {
        ptr_t               wr_ptr;
        ptr_t               rd_ptr;
        cnt_t               mem_cnt;
        logic               out_valid;
        word_t              out_word;
        logic               bready;
        logic               prog_full;
        logic               prog_empty;
        logic               overflow;
        logic               sbit;
        logic               dbit;
        cnt_t               count;
        thresh_t            full_th;
        thresh_t            empty_th;
        logic               ecc_en;
        logic               pready;
        logic [DATA_W-1:0]  prdata;
        logic               pslverr;
    } state_t;

endpackage

// *** rtl/store_if.sv ***
// Port bundle between the FIFO control and its ECC-protected storage.
// Assumes both ends share the same clock.
`timescale 1ns/1ps
interface store_if;
    import bresp_fifo_pkg::*;
    logic   wr_en;
    ptr_t   wr_addr;
    word_t  wr_data;
    logic   inj_single;
    logic   inj_double;
    logic   ecc_en;
    ptr_t   rd_addr;
    word_t  rd_data;
    logic   rd_single;
    logic   rd_double;

    modport ctrl (output wr_en, wr_addr, wr_data, inj_single, inj_double, ecc_en, rd_addr,
                  input rd_data, rd_single, rd_double);
    modport mem  (input wr_en, wr_addr, wr_data, inj_single, inj_double, ecc_en, rd_addr,
                  output rd_data, rd_single, rd_double);
endinterface

// *** rtl/ecc_store.sv ***
// SECDED-protected response storage with error injection on write.
// Assumes the controller never writes and reads one entry in one cycle.
`timescale 1ns/1ps
module ecc_store
    import bresp_fifo_pkg::*;
(
    // Clock
    input  wire logic  i_clk,
    // Storage port
    store_if.mem       st
);
    code_t mem [DEPTH];

    // ****************************************************************
    // Hamming code, parity at powers of two, overall parity in bit 0
    // ****************************************************************
    function automatic code_t ecc_encode(word_t d);
        code_t c;
        int    k;
        c = '0;
        k = 0;
        for (int p = 1; p < CODE_W; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                c[p] = d[k];
                k++;
            end
        end
        for (int i = 0; i < PAR_W; i++)
        begin
            for (int p = 1; p < CODE_W; p++)
            begin
                if ((p & (1 << i)) != 0)
                    c[1 << i] = c[1 << i] ^ c[p];
            end
        end
        c[0] = ^c;
        return c;
    endfunction

    function automatic word_t ecc_extract(code_t c);
        word_t d;
        int    k;
        d = '0;
        k = 0;
        for (int p = 1; p < CODE_W; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                d[k] = c[p];
                k++;
            end
        end
        return d;
    endfunction

    // ****************************************************************
    // Write with injection
    // ****************************************************************
    code_t wr_code;
    always_comb
    begin
        wr_code = ecc_encode(st.wr_data);
        if (st.ecc_en && st.inj_double)
        begin
            wr_code[INJ_BIT_A] = ~wr_code[INJ_BIT_A];
            wr_code[INJ_BIT_B] = ~wr_code[INJ_BIT_B];
        end
        else if (st.ecc_en && st.inj_single)
            wr_code[INJ_BIT_A] = ~wr_code[INJ_BIT_A];
    end

    always_ff @(posedge i_clk)
    begin
        if (st.wr_en)
            mem[st.wr_addr] <= wr_code;
    end

    // ****************************************************************
    // Read and decode
    // ****************************************************************
    code_t            rd_code;
    logic [PAR_W-1:0] syndrome;
    logic             odd;
    always_comb
    begin
        rd_code  = mem[st.rd_addr];
        syndrome = '0;
        for (int p = 1; p < CODE_W; p++)
        begin
            if (rd_code[p])
                syndrome = syndrome ^ PAR_W'(p);
        end
        odd = ^rd_code;
        st.rd_single = 1'b0;
        st.rd_double = 1'b0;
        if (st.ecc_en)
        begin
            // Syndrome past the last code bit means more than one flip
            if (odd && (int'(syndrome) < CODE_W))
            begin
                rd_code[syndrome] = ~rd_code[syndrome];
                st.rd_single = 1'b1;
            end
            else if (syndrome != '0 || odd)
                st.rd_double = 1'b1;
        end
        st.rd_data = ecc_extract(rd_code);
    end
endmodule

// *** bench/bresp_fifo_asserts.sv ***
// Concurrent checks on the write response FIFO top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module bresp_fifo_asserts
    import bresp_fifo_pkg::*;
(
    // Clock, reset, sideband
    input wire logic                                I_MCLK,
    input wire logic                                I_SRST,
    input wire logic [bresp_fifo_pkg::THRESH_W-1:0] I_PROG_FULL_THRESH,
    input wire logic [bresp_fifo_pkg::THRESH_W-1:0] I_PROG_EMPTY_THRESH,
    input wire logic                                O_SBIT_ERR,
    input wire logic                                O_DBIT_ERR,
    input wire logic                                O_OVERFLOW,
    input wire logic                                O_PROG_FULL,
    input wire logic                                O_PROG_EMPTY,
    input wire logic [bresp_fifo_pkg::CNT_W-1:0]    O_DATA_COUNT,
    // Response ports
    input wire logic [bresp_fifo_pkg::ID_W-1:0]     I_M_BID,
    input wire logic [bresp_fifo_pkg::RESP_W-1:0]   I_M_BRESP,
    input wire logic [bresp_fifo_pkg::USER_W-1:0]   I_M_BUSER,
    input wire logic                                I_M_BVALID,
    input wire logic                                O_M_BREADY,
    input wire logic [bresp_fifo_pkg::ID_W-1:0]     O_S_BID,
    input wire logic [bresp_fifo_pkg::RESP_W-1:0]   O_S_BRESP,
    input wire logic [bresp_fifo_pkg::USER_W-1:0]   O_S_BUSER,
    input wire logic                                O_S_BVALID,
    input wire logic                                I_S_BREADY
);
    import bresp_fifo_pkg::*;
    thresh_t fth;
    thresh_t eth;
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_SRST);
    // Thresholds count only as taken during reset
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            fth <= I_PROG_FULL_THRESH;
            eth <= I_PROG_EMPTY_THRESH;
        end
    end
    sequence into_empty;
        O_DATA_COUNT == 5'h00 && I_M_BVALID && O_M_BREADY;
    endsequence
    empty_invalid_a: assert property (O_DATA_COUNT == 5'h00 |-> !O_S_BVALID)
        else $error("valid with nothing stored");
    first_out_a: assert property (into_empty |-> ##2 O_S_BVALID)
        else $error("stored response not presented");
    id_pass_a: assert property (into_empty |-> ##2 O_S_BID == $past(I_M_BID, 2))
        else $error("response id altered");
    // Uncorrectable words are delivered as stored, flagged instead
    resp_pass_a: assert property (into_empty |-> ##2 (O_DBIT_ERR ||
        O_S_BRESP == $past(I_M_BRESP, 2)))
        else $error("response status altered");
    user_pass_a: assert property (into_empty |-> ##2 (O_DBIT_ERR ||
        O_S_BUSER == $past(I_M_BUSER, 2)))
        else $error("user field altered");
    front_hold_a: assert property (O_S_BVALID && !I_S_BREADY |=> O_S_BVALID &&
        $stable(O_S_BID) && $stable(O_S_BRESP) && $stable(O_S_BUSER))
        else $error("front response moved without handshake");
    full_block_a: assert property (O_DATA_COUNT == 5'h11 |-> !O_M_BREADY)
        else $error("ready while full");
    room_ready_a: assert property (O_DATA_COUNT < 5'h10 |-> O_M_BREADY)
        else $error("not ready with room left");
    ovf_after_a: assert property (I_M_BVALID && !O_M_BREADY |=> O_OVERFLOW)
        else $error("refused write not flagged");
    ovf_cause_a: assert property (O_OVERFLOW |-> $past(I_M_BVALID) && !$past(O_M_BREADY))
        else $error("overflow without refused write");
    pfull_level_a: assert property (O_PROG_FULL == (O_DATA_COUNT >= {1'b0, fth}))
        else $error("prog full disagrees with count");
    pempty_level_a: assert property (O_PROG_EMPTY == (O_DATA_COUNT <= {1'b0, eth}))
        else $error("prog empty disagrees with count");
    sbit_with_a: assert property (O_SBIT_ERR |-> O_S_BVALID && !O_DBIT_ERR)
        else $error("single error flag out of place");
    dbit_with_a: assert property (O_DBIT_ERR |-> O_S_BVALID)
        else $error("double error flag without word");
    full_c: cover property (O_DATA_COUNT == 5'h11);
    ovf_c: cover property (O_OVERFLOW);
    sbit_c: cover property (O_SBIT_ERR);
    dbit_c: cover property (O_DBIT_ERR);
endmodule

bind bresp_fifo bresp_fifo_asserts chk_i (.*);

// *** bench/bresp_peer.sv ***
// Far-side model: downstream responder feeding the FIFO, upstream taker.
// Assumes it shares the FIFO clock and reset.
`timescale 1ns/1ps
module bresp_peer
    import bresp_fifo_pkg::*;
(
    // Clock, reset, control
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_send,
    input  wire logic [1:0]            i_rdy_mode,
    // Response ports
    input  wire logic                  i_m_bready,
    input  wire logic                  i_s_bvalid,
    input  wire bresp_fifo_pkg::word_t i_s_word,
    output bresp_fifo_pkg::word_t      o_m_word,
    output logic                       o_m_bvalid,
    output logic                       o_s_bready,
    // Progress
    output logic [7:0]                 o_sent,
    output logic [7:0]                 o_rcvd,
    output logic [7:0]                 o_bad
);
    import bresp_fifo_pkg::*;
    logic [1:0] tick;
    logic [7:0] nx;
    // Sequence k carries k*0x25: covers every status code early
    function automatic word_t pat(input logic [7:0] k);
        return word_t'(k * 8'h25);
    endfunction
    // Modes: 0 always ready, 1 one cycle in four, 2 stalled
    assign o_s_bready = i_rdy_mode == 2'h0 || (i_rdy_mode == 2'h1 && tick == 2'h3);
    assign nx = o_sent + {7'h00, o_m_bvalid & i_m_bready};
    always @(posedge i_clk)
    begin
        tick <= i_rst ? 2'h0 : tick + 2'h1;
        o_m_bvalid <= !i_rst && i_send;
        // Idle lines carry the inverse so no stale word passes as valid
        o_m_word <= i_send ? pat(nx) : ~pat(nx);
        o_sent <= i_rst ? 8'h00 : nx;
        if (i_rst)
        begin
            o_rcvd <= 8'h00;
            o_bad <= 8'h00;
        end
        else if (i_s_bvalid && o_s_bready)
        begin
            o_rcvd <= o_rcvd + 8'h01;
            if (i_s_word !== pat(o_rcvd))
                o_bad <= o_bad + 8'h01;
        end
    end
endmodule

// *** bench/bresp_fifo_bench.sv ***
// Self-checking bench for the write response FIFO.
// Assumes the far-side model and checker files are compiled first.
`timescale 1ns/1ps
module bresp_fifo_bench;
    import bresp_fifo_pkg::*;
    logic I_MCLK = 1'b0, I_SRST = 1'b1, I_S_BREADY, I_M_BVALID, O_M_BREADY, O_S_BVALID;
    logic I_INJECT_SBIT = 1'b0, I_INJECT_DBIT = 1'b0, O_SBIT_ERR, O_DBIT_ERR, O_OVERFLOW;
    logic O_PROG_FULL, O_PROG_EMPTY, O_PREADY, O_PSLVERR, err, send = 1'b0;
    logic I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
    logic [7:0] I_PADDR = 8'h00, sent, rcvd, bad;
    logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
    logic [1:0] rdy_mode = 2'h0;
    thresh_t I_PROG_FULL_THRESH = 4'hc, I_PROG_EMPTY_THRESH = 4'h3;
    wire word_t m_word, s_word;
    cnt_t O_DATA_COUNT;
    int error_cnt = 0, checks = 0, n;

    always #12.5 I_MCLK = ~I_MCLK;

    bresp_fifo dut (.I_MCLK(I_MCLK), .I_SRST(I_SRST), .I_M_BID(m_word[ID_LSB+:ID_W]),
        .I_M_BRESP(m_word[RESP_LSB+:RESP_W]), .I_M_BUSER(m_word[USER_LSB+:USER_W]),
        .I_M_BVALID(I_M_BVALID), .O_M_BREADY(O_M_BREADY), .O_S_BID(s_word[ID_LSB+:ID_W]),
        .O_S_BRESP(s_word[RESP_LSB+:RESP_W]), .O_S_BUSER(s_word[USER_LSB+:USER_W]),
        .O_S_BVALID(O_S_BVALID), .I_S_BREADY(I_S_BREADY), .I_PROG_FULL_THRESH(I_PROG_FULL_THRESH),
        .I_PROG_EMPTY_THRESH(I_PROG_EMPTY_THRESH), .I_INJECT_SBIT(I_INJECT_SBIT),
        .I_INJECT_DBIT(I_INJECT_DBIT), .O_SBIT_ERR(O_SBIT_ERR), .O_DBIT_ERR(O_DBIT_ERR),
        .O_OVERFLOW(O_OVERFLOW), .O_PROG_FULL(O_PROG_FULL), .O_PROG_EMPTY(O_PROG_EMPTY),
        .O_DATA_COUNT(O_DATA_COUNT), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
        .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
        .O_PSLVERR(O_PSLVERR));
    bresp_peer peer (.i_clk(I_MCLK), .i_rst(I_SRST), .i_send(send), .i_rdy_mode(rdy_mode),
        .i_m_bready(O_M_BREADY), .i_s_bvalid(O_S_BVALID), .i_s_word(s_word), .o_m_word(m_word),
        .o_m_bvalid(I_M_BVALID), .o_s_bready(I_S_BREADY), .o_sent(sent), .o_rcvd(rcvd),
        .o_bad(bad));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task end_of_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task bump;
        @(negedge I_MCLK);
        n++;
        if (n > 3000)
        begin
            chk("wait bound", 0, 1);
            end_of_test;
        end
    endtask
    // Thresholds move only once reset is already held
    task rst(input thresh_t fth, input thresh_t eth);
        @(posedge I_MCLK);
        I_SRST <= 1'b1;
        @(posedge I_MCLK);
        {I_PROG_FULL_THRESH, I_PROG_EMPTY_THRESH} <= {fth, eth};
        repeat (3) @(posedge I_MCLK);
        I_SRST <= 1'b0;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_MCLK);
        {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {2'b10, w, a, d};
        @(posedge I_MCLK);
        I_PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge I_MCLK);
            n++;
        end
        while (O_PREADY !== 1'b1 && n < 50);
        {rd, err} = {O_PRDATA, O_PSLVERR};
        {I_PSEL, I_PENABLE} <= 2'b00;
        chk("apb ready", n < 50, 1);
        if (n >= 50)
            end_of_test;
    endtask
    task drain;
        @(posedge I_MCLK);
        send <= 1'b0;
        n = 0;
        repeat (4) bump;
        while (rcvd !== sent || O_DATA_COUNT !== 5'h00)
            bump;
        chk("order kept", bad, 0);
        chk("empty flag", O_PROG_EMPTY, 1);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        @(negedge I_MCLK);
        chk("bready", {O_M_BREADY, O_S_BVALID, O_PROG_FULL, O_PROG_EMPTY}, 4'b1001);
        apb(1'b1, STATUS_OFFSET, 32'hffffffff);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("thresholds", rd[23:16], 8'h3c);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk("ecc enable", rd[CTRL_ECC_EN_POS], CTRL_ECC_EN_RESET);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {err, rd[30:0]}, {1'b1, 31'h0});
    endtask
    task t_stream;
        rst(4'hc, 4'h3);
        send <= 1'b1;
        n = 0;
        while (sent < 8'd20)
            bump;
        drain;
    endtask
    task t_fill;
        rst(4'h5, 4'h3);
        {send, rdy_mode} <= 3'b110;
        n = 0;
        while (O_DATA_COUNT !== 5'h11)
            bump;
        repeat (3) @(negedge I_MCLK);
        chk("full", {O_M_BREADY, O_PROG_FULL, O_OVERFLOW}, 3'b011);
        chk("taken", sent, 8'd17);
        rdy_mode <= 2'h1;
        drain;
    endtask
    task t_ecc(input logic s, input logic d, input logic en, input logic [1:0] exp);
        rdy_mode <= 2'h0;
        rst(4'hc, 4'h3);
        apb(1'b1, CTRL_OFFSET, {31'h0, en});
        @(posedge I_MCLK);
        send <= 1'b1;
        @(posedge I_MCLK);
        {send, I_INJECT_SBIT, I_INJECT_DBIT} <= {1'b0, s, d};
        @(posedge I_MCLK);
        {I_INJECT_SBIT, I_INJECT_DBIT} <= 2'b00;
        n = 0;
        while (O_S_BVALID !== 1'b1)
            bump;
        chk("error flags", {O_SBIT_ERR, O_DBIT_ERR}, exp);
        repeat (3) @(negedge I_MCLK);
        if (!d)
            chk("corrected word", {rcvd, bad}, 16'h0100);
    endtask

    initial
    begin
        repeat (4) @(posedge I_MCLK);
        I_SRST <= 1'b0;
        t_reset;
        t_stream;
        t_fill;
        t_ecc(1'b1, 1'b0, 1'b1, 2'b10);
        t_ecc(1'b0, 1'b1, 1'b1, 2'b01);
        t_ecc(1'b1, 1'b1, 1'b1, 2'b01);
        t_ecc(1'b1, 1'b0, 1'b0, 2'b00);
        end_of_test;
    end
endmodule
